// ==== hdl/dma_channel.sv ====
// Summary of operation
// R1 - Half-count wrap interrupt when selected and wrapping
// R2 - Wrap interrupt on each wrap when selected
// R3 - Both selects give both interrupt kinds
// R4 - Destination address increments, holds or wraps
// R5 - Destination wrap reloads address and count
// R6 - Wrapping repeats until channel is switched off
// R7 - Switch-off finishes step, discards staged data
// R8 - Source address increments, holds or wraps
// R9 - Source wrap reloads address and count
// R10 - Direction field selects memory or peripheral paths
// R11 - Engine reset clears state, keeps control bits (code also clears the trigger bit)
// R12 - Engine reset bit clears itself shortly
// R13 - Channel on bit enables servicing
// R14 - Channel off ignores requests, bus idle
// R15 - Engine reset also clears channel on
// R16 - Trigger starts transfer, clears on completion
// R17 - Beat width word, byte or half-word
// R18 - Bus error stops until reset and retrigger
// R19 - Events latch as sticky status flags
module dma_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic periph_req,
  output logic bm_valid,
  output logic bm_write,
  output logic [31:0] bm_addr,
  output logic [1:0] bm_size,
  output logic [31:0] bm_wdata,
  input wire logic bm_ready,
  input wire logic [31:0] bm_rdata,
  input wire logic bm_error,
  output logic irq
);
  // Control fields held by software.
  logic channel_on;
  logic trigger;
  logic [1:0] direction;
  logic [1:0] src_mode;
  logic [1:0] dest_mode;
  logic [3:0] wrap_sel;
  logic [1:0] beat_width;
  logic [1:0] srst_cnt;
  // Start registers and interrupt mask.
  logic [31:0] src_start;
  logic [31:0] dest_start;
  logic [15:0] count_start;
  logic [3:0] irq_mask;
  logic [3:0] irq_status;
  // Engine state, current pointers and the staging word.
  dma_chan_pkg::engine_state_t state;
  logic [31:0] src_now;
  logic [31:0] dest_now;
  logic [15:0] count_now;
  logic [31:0] staging_word;

  // Register decode; a write lands only at the access edge, where pready is high.
  wire setup = psel & ~penable;
  wire wr_cycle = psel & penable & pready & pwrite;
  wire hit_ctl = (paddr == dma_chan_pkg::off_control);
  wire hit_sst = (paddr == dma_chan_pkg::off_src_start);
  wire hit_dst = (paddr == dma_chan_pkg::off_dest_start);
  wire hit_cst = (paddr == dma_chan_pkg::off_count_start);
  wire hit_ptr = (paddr == dma_chan_pkg::off_staging_ptr);
  wire hit_snw = (paddr == dma_chan_pkg::off_src_now);
  wire hit_dnw = (paddr == dma_chan_pkg::off_dest_now);
  wire hit_cnw = (paddr == dma_chan_pkg::off_count_now);
  wire hit_msk = (paddr == dma_chan_pkg::off_irq_mask);
  wire hit_sts = (paddr == dma_chan_pkg::off_irq_status);
  wire mapped = hit_ctl | hit_sst | hit_dst | hit_cst | hit_ptr | hit_snw | hit_dnw |
                hit_cnw | hit_msk | hit_sts;
  wire wr_ctl = wr_cycle & hit_ctl;
  wire srst_req = wr_ctl & pwdata[dma_chan_pkg::pos_soft_reset];
  wire srst_active = (srst_cnt != 2'h0);
  wire trig_write = wr_ctl & pwdata[dma_chan_pkg::pos_trigger];

  // Read view of the control register; reserved bits read as zero.
  wire [31:0] ctl_view = {8'h00, trigger, 2'b00, beat_width, 3'b000, wrap_sel, 4'h0,
                          dest_mode, src_mode, direction, srst_active, channel_on};
  // Pointer into the staging word, the byte lane of the next write.
  wire [31:0] ptr_view = {28'h0, 2'b00, dest_now[1:0]};
  wire [31:0] rd_mux = hit_ctl ? ctl_view :
                       hit_sst ? src_start :
                       hit_dst ? dest_start :
                       hit_cst ? {16'h0, count_start} :
                       hit_ptr ? ptr_view :
                       hit_snw ? src_now :
                       hit_dnw ? dest_now :
                       hit_cnw ? {16'h0, count_now} :
                       hit_msk ? {28'h0, irq_mask} :
                       hit_sts ? {28'h0, irq_status} : 32'h0;

  // Beat size: memory to memory always moves words, peripheral paths use the
  // width field, and the reserved width code falls back to a word.
  wire mem_only = (direction == dma_chan_pkg::dir_mem_mem); // R10
  wire [1:0] size_sel = mem_only ? dma_chan_pkg::width_word :
                        (beat_width == 2'h3) ? dma_chan_pkg::width_word : beat_width; // R17
  wire [2:0] step_bytes = (size_sel == dma_chan_pkg::width_byte) ? 3'h1 :
                          (size_sel == dma_chan_pkg::width_half) ? 3'h2 : 3'h4; // R17
  wire wrap_on = (src_mode == dma_chan_pkg::mode_wrap) | (dest_mode == dma_chan_pkg::mode_wrap);

  // Next pointer values from the shared stepper.
  logic [31:0] src_next;
  logic [31:0] dest_next;
  addr_stepper src_step (
    .mode(src_mode),
    .addr_now(src_now),
    .step_bytes(step_bytes),
    .addr_next(src_next)
  );
  addr_stepper dest_step (
    .mode(dest_mode),
    .addr_now(dest_now),
    .step_bytes(step_bytes),
    .addr_next(dest_next)
  );

  // Step bookkeeping; a short final beat still brings the count to zero.
  wire [15:0] count_after = (count_now <= {13'h0, step_bytes}) ? 16'h0 :
                            count_now - {13'h0, step_bytes};
  wire read_ok = (state == dma_chan_pkg::st_read) & bm_ready & ~bm_error;
  wire write_ok = (state == dma_chan_pkg::st_write) & bm_ready & ~bm_error;
  wire bus_fail = bm_valid & bm_ready & bm_error;
  wire run_out = write_ok & (count_after == 16'h0);
  wire wrap_end = run_out & wrap_on & channel_on;
  wire ev_done = run_out & ~wrap_end;
  wire ev_half = write_ok & wrap_on & (count_after == {1'b0, count_start[15:1]});
  wire ev_wrap = wrap_end;
  // Peripheral directions wait for a request; memory copies run free.
  wire may_start = trigger & channel_on & ~srst_active & (mem_only | periph_req); // R13 R14

  // APB answer: zero wait states, data and error registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= setup & ~mapped;
    end
  end

  // Mode fields keep their value across an engine reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction <= 2'h0;
      src_mode <= 2'h0;
      dest_mode <= 2'h0;
      wrap_sel <= 4'h0;
      beat_width <= 2'h0;
    end else if (wr_ctl) begin
      direction <= pwdata[dma_chan_pkg::pos_direction +: 2];
      src_mode <= pwdata[dma_chan_pkg::pos_src_mode +: 2];
      dest_mode <= pwdata[dma_chan_pkg::pos_dest_mode +: 2];
      wrap_sel <= pwdata[dma_chan_pkg::pos_wrap_sel +: 4];
      beat_width <= pwdata[dma_chan_pkg::pos_beat_width +: 2];
    end
  end

  // Engine reset pulse counter; writing zero to the bit changes nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srst_cnt <= 2'h0;
    end else if (srst_req) begin
      srst_cnt <= dma_chan_pkg::soft_reset_cycles; // R11
    end else if (srst_active) begin
      srst_cnt <= srst_cnt - 2'h1; // R12
    end
  end

  // Channel on follows software, but an engine reset forces it off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_on <= 1'b0;
    end else if (srst_req | srst_active) begin
      channel_on <= 1'b0; // R15
    end else if (wr_ctl) begin
      channel_on <= pwdata[dma_chan_pkg::pos_channel_on]; // R13
    end
  end

  // Trigger: software sets it, the engine clears it at the end or on error.
  // A set in the same cycle as the end or error clear wins; an engine reset still clears the trigger bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger <= 1'b0;
    end else if (srst_req | srst_active) begin
      trigger <= 1'b0;
    end else if (trig_write) begin
      trigger <= 1'b1; // R16
    end else if (ev_done | bus_fail) begin
      trigger <= 1'b0; // R16 R18
    end
  end

  // Start registers and interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_start <= dma_chan_pkg::rst_start_addr;
      dest_start <= dma_chan_pkg::rst_start_addr;
      count_start <= 16'h0;
      irq_mask <= dma_chan_pkg::rst_irq_mask;
    end else begin
      if (wr_cycle & hit_sst) src_start <= pwdata;
      if (wr_cycle & hit_dst) dest_start <= pwdata;
      if (wr_cycle & hit_cst) count_start <= pwdata[15:0];
      if (wr_cycle & hit_msk) irq_mask <= pwdata[3:0];
    end
  end

  // Sticky event flags, cleared by writing one; a new event beats the clear.
  wire [3:0] ev_vec = {bus_fail, ev_done, ev_wrap & wrap_sel[0], ev_half & wrap_sel[2]}; // R1 R2 R3
  wire [3:0] clr_vec = (wr_cycle & hit_sts) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (irq_status & ~clr_vec) | ev_vec; // R19
    end
  end

  // Level interrupt while any unmasked flag is pending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Transfer engine: one read into the staging word, then one write from it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dma_chan_pkg::st_idle;
      src_now <= dma_chan_pkg::rst_now_addr;
      dest_now <= dma_chan_pkg::rst_now_addr;
      count_now <= 16'h0;
      staging_word <= 32'h0;
      bm_valid <= 1'b0;
      bm_write <= 1'b0;
      bm_addr <= 32'h0;
      bm_size <= 2'h0;
      bm_wdata <= 32'h0;
    end else if (srst_active) begin
      // Engine reset drops any bus request and returns the pointers.
      state <= dma_chan_pkg::st_idle; // R11 R18
      src_now <= dma_chan_pkg::rst_now_addr;
      dest_now <= dma_chan_pkg::rst_now_addr;
      count_now <= 16'h0;
      bm_valid <= 1'b0;
      bm_write <= 1'b0;
    end else begin
      case (state)
        dma_chan_pkg::st_idle: begin
          if (trig_write) begin
            // A fresh trigger loads the pointers from the start registers.
            src_now <= src_start;
            dest_now <= dest_start;
            count_now <= count_start;
          end else if (may_start && count_now != 16'h0) begin
            state <= dma_chan_pkg::st_read; // R10
            bm_valid <= 1'b1;
            bm_write <= 1'b0;
            bm_addr <= src_now;
            bm_size <= size_sel; // R17
          end
        end
        dma_chan_pkg::st_read: begin
          if (bus_fail) begin
            state <= dma_chan_pkg::st_halt; // R18
            bm_valid <= 1'b0;
          end else if (read_ok && channel_on) begin
            state <= dma_chan_pkg::st_write;
            staging_word <= bm_rdata;
            bm_write <= 1'b1;
            bm_addr <= dest_now;
            bm_wdata <= bm_rdata;
          end else if (read_ok) begin
            // Switched off mid-step: the read ends, staged data is dropped.
            state <= dma_chan_pkg::st_idle; // R7
            bm_valid <= 1'b0;
          end
        end
        dma_chan_pkg::st_write: begin
          if (bus_fail) begin
            state <= dma_chan_pkg::st_halt; // R18
            bm_valid <= 1'b0;
            bm_write <= 1'b0;
          end else if (write_ok) begin
            state <= dma_chan_pkg::st_idle;
            bm_valid <= 1'b0;
            bm_write <= 1'b0;
            if (wrap_end) begin
              // Wrap reload; it repeats for as long as the channel stays on.
              src_now <= (src_mode == dma_chan_pkg::mode_wrap) ? src_start : src_next; // R9 R6
              dest_now <= (dest_mode == dma_chan_pkg::mode_wrap) ? dest_start : dest_next; // R5
              count_now <= count_start; // R5 R9
            end else begin
              src_now <= src_next; // R8
              dest_now <= dest_next; // R4
              count_now <= count_after;
            end
          end
        end
        dma_chan_pkg::st_halt: begin
          // Only an engine reset leaves this state.
          bm_valid <= 1'b0; // R18
        end
        default: begin
          state <= dma_chan_pkg::st_idle;
          bm_valid <= 1'b0;
        end
      endcase
    end
  end

  // Checks kept beside the logic; helper sequences name the step phases.
  sequence s_write_done;
    write_ok;
  endsequence
  sequence s_read_done_off;
    read_ok && !channel_on;
  endsequence

  a_half_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R1
    s_write_done ##0 (ev_half && wrap_sel[2] && !srst_active) |=> irq_status[0])
    else $error("half event did not latch");
  a_wrap_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R2
    s_write_done ##0 (wrap_end && wrap_sel[0] && !srst_active) |=> irq_status[1])
    else $error("wrap event did not latch");
  a_wrap_reload: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (wrap_end && !srst_active) |=> (count_now == count_start))
    else $error("wrap did not reload the count");
  a_fixed_dest: assert property (@(posedge pclk) disable iff (!presetn) // R4
    s_write_done ##0 (dest_mode == dma_chan_pkg::mode_fixed && !wrap_end && !srst_active)
    |=> $stable(dest_now))
    else $error("fixed destination moved");
  a_src_incr: assert property (@(posedge pclk) disable iff (!presetn) // R8
    s_write_done ##0 (src_mode == dma_chan_pkg::mode_incr && !srst_active)
    |=> (src_now == $past(src_now) + {29'h0, $past(step_bytes)}))
    else $error("source did not advance by one beat");
  a_discard_off: assert property (@(posedge pclk) disable iff (!presetn) // R7
    s_read_done_off |=> (state == dma_chan_pkg::st_idle && !bm_valid) [*2])
    else $error("staged data written after switch off");
  a_off_no_start: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (state == dma_chan_pkg::st_idle && !channel_on) |=> !bm_valid)
    else $error("bus request while channel off");
  a_srst_clears: assert property (@(posedge pclk) disable iff (!presetn) // R15
    srst_req |=> (!channel_on && !trigger) ##3 !srst_active)
    else $error("engine reset did not clear or end");
  a_word_mem: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (bm_valid && mem_only) |-> (bm_size == dma_chan_pkg::width_word))
    else $error("memory copy not word sized");
  a_done_trigger: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (ev_done && !trig_write && !srst_active) |=> !trigger ##1 !trigger)
    else $error("trigger not cleared on completion");
  a_err_halt: assert property (@(posedge pclk) disable iff (!presetn) // R18
    (bus_fail && !srst_active) |=> (state == dma_chan_pkg::st_halt && !bm_valid))
    else $error("bus error did not stop the engine");
endmodule

// ==== hdl/dma_chan_pkg.sv ====
package dma_chan_pkg;
  // Register byte offsets within the channel window.
  localparam logic [7:0] off_control = 8'h00;
  localparam logic [7:0] off_src_start = 8'h04;
  localparam logic [7:0] off_dest_start = 8'h08;
  localparam logic [7:0] off_count_start = 8'h0C;
  localparam logic [7:0] off_staging_ptr = 8'h10;
  localparam logic [7:0] off_src_now = 8'h14;
  localparam logic [7:0] off_dest_now = 8'h18;
  localparam logic [7:0] off_count_now = 8'h1C;
  localparam logic [7:0] off_irq_mask = 8'h20;
  localparam logic [7:0] off_irq_status = 8'h24;
  // Control register field positions.
  localparam int pos_channel_on = 0;
  localparam int pos_soft_reset = 1;
  localparam int pos_direction = 2;
  localparam int pos_src_mode = 4;
  localparam int pos_dest_mode = 6;
  localparam int pos_wrap_sel = 12;
  localparam int pos_beat_width = 19;
  localparam int pos_trigger = 23;
  // Interrupt status bit positions.
  localparam int pos_ev_half = 0;
  localparam int pos_ev_wrap = 1;
  localparam int pos_ev_done = 2;
  localparam int pos_ev_error = 3;
  // Values after reset.
  localparam logic [31:0] rst_start_addr = 32'h4000_0000;
  localparam logic [31:0] rst_now_addr = 32'hFFFF_FFFF;
  localparam logic [3:0] rst_irq_mask = 4'h1;
  // Engine reset pulse length in clock cycles.
  localparam logic [1:0] soft_reset_cycles = 2'h3;
  // Address modes.
  localparam logic [1:0] mode_incr = 2'h0;
  localparam logic [1:0] mode_fixed = 2'h2;
  localparam logic [1:0] mode_wrap = 2'h3;
  // Directions.
  localparam logic [1:0] dir_mem_mem = 2'h0;
  localparam logic [1:0] dir_per_mem = 2'h1;
  localparam logic [1:0] dir_mem_per = 2'h2;
  // Beat widths, also used as bus size codes.
  localparam logic [1:0] width_word = 2'h0;
  localparam logic [1:0] width_byte = 2'h1;
  localparam logic [1:0] width_half = 2'h2;
  // Engine states.
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_read = 2'b01,
    st_write = 2'b10,
    st_halt = 2'b11
  } engine_state_t;
endpackage

// ==== hdl/addr_stepper.sv ====
// Works out the address that follows one transfer step for one pointer.
module addr_stepper (
  input wire logic [1:0] mode,
  input wire logic [31:0] addr_now,
  input wire logic [2:0] step_bytes,
  output logic [31:0] addr_next
);
  // Fixed mode holds the address; increment and wrap both advance it, since a
  // wrapping pointer only differs when the count runs out and it is reloaded.
  wire hold_addr = (mode == dma_chan_pkg::mode_fixed);
  wire [31:0] advanced = addr_now + {29'h0, step_bytes};
  assign addr_next = hold_addr ? addr_now : advanced;
endmodule

// ==== testbench/bus_partner.sv ====
// Far-side model: answers reads with address-derived data and logs writes behind the bus master port.
module bus_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bm_valid,
  input wire logic bm_write,
  input wire logic [31:0] bm_addr,
  input wire logic [1:0] bm_size,
  input wire logic [31:0] bm_wdata,
  input wire logic [3:0] delay,
  input wire logic err_inject,
  output logic bm_ready,
  output logic [31:0] bm_rdata,
  output logic bm_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waited; // Wait cycles spent on the open request.
  logic [31:0] rdata_q; // Read data line; toggles when it carries nothing.
  logic [31:0] wr_addr[$], wr_data[$]; // Log of accepted writes, read by the bench.
  logic [1:0] wr_size[$];
  assign bm_rdata = rdata_q;
  // Answers after a chosen wait; read data is a fixed function of the address.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bm_ready <= 1'b0;
      bm_error <= 1'b0;
      rdata_q <= 32'h0;
      waited <= 4'h0;
    end else if (bm_ready) begin
      // The request was taken at this edge, so the data line goes stale.
      if (bm_valid && bm_write) begin
        wr_addr.push_back(bm_addr);
        wr_data.push_back(bm_wdata);
        wr_size.push_back(bm_size);
      end
      bm_ready <= 1'b0;
      bm_error <= 1'b0;
      rdata_q <= ~rdata_q;
      waited <= 4'h0;
    end else if (bm_valid && waited >= delay) begin
      bm_ready <= 1'b1;
      bm_error <= err_inject;
      rdata_q <= bm_write ? ~rdata_q : bm_addr ^ 32'h5A5A_5A5A;
    end else begin
      // Waiting or idle: the data line toggles and never holds a steady value.
      waited <= bm_valid ? waited + 4'h1 : 4'h0;
      rdata_q <= ~rdata_q;
    end
  end
endmodule

// ==== testbench/dma_channel_addressing_control_tb.sv ====
// Self-checking bench for one DMA channel, driven over APB.
module dma_channel_addressing_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, periph_req, slv;
  logic bm_valid, bm_write, bm_ready, bm_error, irq, err_inject;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, bm_addr, bm_wdata, bm_rdata, rd;
  logic [1:0] bm_size;
  logic [3:0] delay;
  int error_cnt, n_tests, busy;
  // One ordinary transfer: direction, source mode, dest mode, width, bytes.
  typedef struct {logic [1:0] d, s, m, w; logic [31:0] cnt;} row_t;
  localparam logic [31:0] src = 32'h2000_0100, dst = 32'h2000_0800;
  row_t rows [5] = '{'{2'h0, 2'h0, 2'h0, 2'h0, 32'hC}, '{2'h0, 2'h2, 2'h0, 2'h0, 32'h8},
    '{2'h1, 2'h2, 2'h0, 2'h1, 32'h3}, '{2'h2, 2'h0, 2'h2, 2'h2, 32'h4},
    '{2'h1, 2'h2, 2'h0, 2'h0, 32'h8}};
  logic [31:0] rv [10] = '{32'h0, 32'h4000_0000, 32'h4000_0000, 32'h0, 32'h0,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h1, 32'h0};
  logic [3:0] sels [3] = '{4'h4, 4'h1, 4'h5};
  dma_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .bm_valid(bm_valid), .bm_write(bm_write),
    .bm_addr(bm_addr), .bm_size(bm_size), .bm_wdata(bm_wdata), .bm_ready(bm_ready),
    .bm_rdata(bm_rdata), .bm_error(bm_error), .irq(irq));
  bus_partner PARTNER (.pclk(pclk), .presetn(presetn), .bm_valid(bm_valid),
    .bm_write(bm_write), .bm_addr(bm_addr), .bm_size(bm_size), .bm_wdata(bm_wdata),
    .delay(delay), .err_inject(err_inject), .bm_ready(bm_ready), .bm_rdata(bm_rdata),
    .bm_error(bm_error));
  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Counts cycles with an open bus request.
  always @(posedge pclk) begin
    if (bm_valid === 1'b1) busy++;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compares one value; an unknown bit matches only an unknown in the expected value.
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd & mask, exp, "register read");
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Polls the status register until all the given bits are set, bounded.
  task automatic wait_st(input logic [31:0] b);
    rd = 32'h0;
    for (int i = 0; i < 400 && (rd & b) !== b; i++) apb(1'b0, dma_chan_pkg::off_irq_status, 0);
    if ((rd & b) !== b) error_cnt++;
  endtask
  // Loads start registers, clears status and the write log, then writes control.
  task automatic start(input logic [31:0] cnt, input logic [31:0] cw);
    PARTNER.wr_addr.delete();
    PARTNER.wr_data.delete();
    PARTNER.wr_size.delete();
    apb(1'b1, dma_chan_pkg::off_src_start, src);
    apb(1'b1, dma_chan_pkg::off_dest_start, dst);
    apb(1'b1, dma_chan_pkg::off_count_start, cnt);
    apb(1'b1, dma_chan_pkg::off_irq_status, 32'hF);
    apb(1'b1, dma_chan_pkg::off_control, cw);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] d, s, m, w, input logic [3:0] sel,
    input logic rst, on, trg);
    return {8'h00, trg, 2'h0, w, 3'h0, sel, 4'h0, m, s, d, rst, on};
  endfunction
  // Expected pointer after k steps; fixed mode never moves.
  function automatic logic [31:0] at(input logic [31:0] b, input logic [1:0] m, input int k,
    input int st);
    return (m == 2'h2) ? b : b + 32'(k * st);
  endfunction
  // Hang guard, far above the run length.
  initial begin
    #300000;
    error_cnt++;
    summarize();
  end
  initial begin
    row_t r;
    int st, b0;
    {psel, penable, pwrite, paddr, pwdata, err_inject} = '0;
    periph_req = 1'b1;
    delay = 4'h0;
    presetn = 1'b0;
    idle(2);
    presetn <= 1'b1;
    // Ordinary transfers, one per row, with the far side answering ever slower.
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      delay <= 4'(i * 2);
      st = (r.d == 2'h0 || r.w == 2'h0) ? 4 : (r.w == 2'h1 ? 1 : 2);
      start(r.cnt, ctl(r.d, r.s, r.m, r.w, 4'h0, 1'b0, 1'b1, 1'b1));
      wait_st(32'h4);
      check(32'(PARTNER.wr_addr.size()), r.cnt / st, "steps");
      foreach (PARTNER.wr_addr[k]) begin
        check(PARTNER.wr_addr[k], at(dst, r.m, k, st), "dest");
        check(PARTNER.wr_data[k], at(src, r.s, k, st) ^ 32'h5A5A_5A5A, "data");
        check(32'(PARTNER.wr_size[k]), 32'(r.d == 2'h0 ? 2'h0 : r.w), "size");
      end
      rchk(dma_chan_pkg::off_control, 32'h0080_0000, 32'h0);
      rchk(dma_chan_pkg::off_src_now, '1, at(src, r.s, r.cnt / st, st));
      rchk(dma_chan_pkg::off_dest_now, '1, at(dst, r.m, r.cnt / st, st));
      rchk(dma_chan_pkg::off_count_now, '1, 32'h0);
    end
    delay <= 4'h1;
    // Second reset in mid-run, then reset values and access kinds.
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) if (i != 4) rchk(8'(i * 4), '1, rv[i]);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, slv}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, dma_chan_pkg::off_src_now, 32'h1234_5678);
    rchk(dma_chan_pkg::off_src_now, '1, 32'hFFFF_FFFF);
    // Channel off or no peripheral request: a trigger must not reach the bus.
    for (int j = 0; j < 2; j++) begin
      periph_req <= 1'(j == 0);
      b0 = busy;
      start(32'h8, ctl(2'(j), 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'(j), 1'b1));
      idle(20);
      check(busy, b0, "bus quiet");
      periph_req <= 1'b1;
      apb(1'b1, dma_chan_pkg::off_control, ctl(2'(j), 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1));
      wait_st(32'h4);
      check(32'(PARTNER.wr_addr.size()), 32'h2, "steps after enable");
    end
    // Wraparound with each event select; events stick until cleared.
    apb(1'b1, dma_chan_pkg::off_irq_mask, 32'h3);
    for (int j = 0; j < 3; j++) begin
      start(32'h8, ctl(2'h0, 2'h3, 2'h3, 2'h0, sels[j], 1'b0, 1'b1, 1'b1));
      wait_st({30'h0, sels[j][0], sels[j][2]});
      check(rd & 32'h3, {30'h0, sels[j][0], sels[j][2]}, "wrap events");
      for (int t = 0; t < 300 && PARTNER.wr_addr.size() < 6; t++) idle(1);
      check(PARTNER.wr_addr[2], dst, "dest reload");
      check(PARTNER.wr_addr[3], dst + 32'h4, "dest after reload");
      check(PARTNER.wr_data[2], src ^ 32'h5A5A_5A5A, "source reload");
      check({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b1, dma_chan_pkg::off_control, ctl(2'h0, 2'h3, 2'h3, 2'h0, sels[j], 1'b0, 1'b0, 1'b0));
      idle(4);
      b0 = busy;
      idle(20);
      check(busy, b0, "wrap stopped");
      apb(1'b1, dma_chan_pkg::off_irq_mask, 32'h0);
      idle(2);
      check({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, dma_chan_pkg::off_irq_mask, 32'h3);
      apb(1'b1, dma_chan_pkg::off_irq_status, 32'h3);
      rchk(dma_chan_pkg::off_irq_status, 32'h3, 32'h0);
    end
    // Engine reset keeps the mode fields and drops channel on and pointers.
    apb(1'b1, dma_chan_pkg::off_control, ctl(2'h1, 2'h2, 2'h3, 2'h0, 4'h5, 1'b1, 1'b1, 1'b0));
    idle(6);
    rchk(dma_chan_pkg::off_control, '1, ctl(2'h1, 2'h2, 2'h3, 2'h0, 4'h5, 1'b0, 1'b0, 1'b0));
    rchk(dma_chan_pkg::off_src_now, '1, 32'hFFFF_FFFF);
    rchk(dma_chan_pkg::off_count_now, '1, 32'h0);
    // Bus error halts the channel until an engine reset and a new trigger.
    err_inject <= 1'b1;
    start(32'h8, ctl(2'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1));
    wait_st(32'h8);
    err_inject <= 1'b0;
    check(32'(PARTNER.wr_addr.size()), 32'h0, "no write after error");
    rchk(dma_chan_pkg::off_control, 32'h0080_0000, 32'h0);
    b0 = busy;
    apb(1'b1, dma_chan_pkg::off_control, ctl(2'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1));
    idle(20);
    check(busy, b0, "halted");
    apb(1'b1, dma_chan_pkg::off_control, 32'h2);
    idle(6);
    start(32'h8, ctl(2'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1));
    wait_st(32'h4);
    check(32'(PARTNER.wr_addr.size()), 32'h2, "steps after recovery");
    // Switch-off during a slow read: the read completes, nothing is written.
    delay <= 4'hA;
    start(32'h8, ctl(2'h0, 2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b1, 1'b1));
    for (int t = 0; t < 50 && bm_valid !== 1'b1; t++) idle(1);
    apb(1'b1, dma_chan_pkg::off_control, 32'h0);
    idle(30);
    check(32'(PARTNER.wr_addr.size()), 32'h0, "staged data dropped");
    summarize();
  end
endmodule
